// *** rtl/timer_pwm_regs.vh ***
// Purpose: Register map, field positions and reset values of the timer/PWM block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   All fields sit in the low bits of their word; upper bits read zero
// Operation
// - 32-bit count advances once per expiry of a 32-bit prescale divider.
// - Count source selects internal clock or transitions of an external input.
// - Two 32-bit capture channels latch the count on input edges, optional interrupt.
// - Seven timer matches let counting continue, optionally raising an interrupt.
// - A match may halt the counter, optionally interrupting at the same event.
// - A match may clear the counter to zero, optionally interrupting too.
// - Four match outputs each go low, high, toggle or hold on a match.
// - Two matches can issue timed transfer requests to the DMA controller.
// - PWM variant has seven matches; its outputs come from match events.
// - In PWM mode match 0 resets the count and sets the shared period.
// - Single-edge PWM outputs rise at the cycle-period match.
// - Single-edge output n falls at its own match register n.
// - Double-edge output uses one match to rise, another to fall.
// - New match values act only after release, synchronised to the period start.
// - A single-edge output programmed constant low does not rise at period start.
// - With PWM mode off the block is a plain timer/counter with prescaler.
`ifndef TIMER_PWM_REGS_VH
`define TIMER_PWM_REGS_VH

// Register byte offsets
`define OFS_INT_STATUS  8'h00
`define OFS_INT_MASK    8'h04
`define OFS_CTRL        8'h08
`define OFS_COUNT       8'h0C
`define OFS_PRESCALE    8'h10
`define OFS_PRESC_CNT   8'h14
`define OFS_MATCH_CTRL  8'h18
`define OFS_MATCH0      8'h1C
`define OFS_MATCH6      8'h34
`define OFS_CAP_CTRL    8'h38
`define OFS_CAP0        8'h3C
`define OFS_CAP1        8'h40
`define OFS_EXT_MATCH   8'h44
`define OFS_COUNT_CTRL  8'h48
`define OFS_PWM_CTRL    8'h4C
`define OFS_LATCH_EN    8'h50
`define OFS_DMA_CTRL    8'h54

// Control register fields
`define CTRL_ENABLE     0
`define CTRL_RESET      1
`define CTRL_PWM_MODE   3

// Match control: three bits per match
`define MC_INT          0
`define MC_RESET        1
`define MC_STOP         2

// Capture control: three bits per channel
`define CC_RISE         0
`define CC_FALL         1
`define CC_INT          2

// Count control fields
`define CNT_MODE_TIMER  2'h0
`define CNT_MODE_RISE   2'h1
`define CNT_MODE_FALL   2'h2
`define CNT_MODE_BOTH   2'h3
`define CNT_SEL_BIT     2

// Status bit of capture channel 0 (channel 1 follows)
`define ST_CAP0         7

// External match actions
`define EM_NONE         2'h0
`define EM_LOW          2'h1
`define EM_HIGH         2'h2
`define EM_TOGGLE       2'h3

// Reset values
`define RST_WORD        32'h0000_0000

`endif

// *** rtl/match_unit.v ***
// Purpose: One match register with shadow copy and count comparator
// Assumes: Shadow takes every write; active copy follows it directly or on load
// Notes:   Buffered mode keeps the comparator value stable until a period start
`timescale 1ns/100ps
`default_nettype none
module match_unit #(
	parameter W = 32
) (
	// Clock and reset
	input  wire         clk,
	input  wire         rst_b,
	// Software side
	input  wire         wr_en,
	input  wire [W-1:0] wr_data,
	input  wire         buffered,
	input  wire         load_now,
	// Counter side
	input  wire [W-1:0] count,
	input  wire         tick,
	output reg  [W-1:0] shadow,
	output reg  [W-1:0] active,
	output wire         hit
);

	// Shadow and active copies; a write in buffered mode waits for release
	always @(posedge clk) begin
		if (!rst_b) begin
			shadow <= {W{1'b0}};
			active <= {W{1'b0}};
		end else begin
			if (wr_en)
				shadow <= wr_data;
			if (wr_en && !buffered)
				active <= wr_data;
			else if (load_now)
				active <= shadow;
		end
	end

	// Match is judged only when the prescaler expires
	assign hit = tick && (count == active);

endmodule
`default_nettype wire

// *** rtl/timer_counter_pwm.v ***
// Purpose: 32-bit timer/counter with prescaler, captures, matches and PWM outputs
// Assumes: All inputs synchronous to clk; reads return data one cycle later
// Notes:   Match 0 is cycle_period_match in PWM mode; registers in timer_pwm_regs.vh
`timescale 1ns/100ps
`default_nettype none
`include "timer_pwm_regs.vh"
module timer_counter_pwm #(
	parameter NUM_MATCH = 7,
	parameter NUM_PWM   = 6
) (
	// Clock and reset
	input  wire                 clk,
	input  wire                 rst_b,
	// Register port
	input  wire [7:0]           addr,
	input  wire [31:0]          wr_data,
	input  wire                 wr_en,
	input  wire                 rd_en,
	output reg  [31:0]          rd_data,
	// External event inputs
	input  wire [1:0]           cap_in,
	// Outputs
	output reg  [3:0]           ext_match,
	output reg  [NUM_PWM:1]     pwm_out,
	output reg  [1:0]           dma_req,
	output wire                 irq
);

	// Software registers
	reg  [8:0]              int_status;
	reg  [8:0]              int_mask;
	reg  [3:0]              ctrl;
	reg  [31:0]             count;
	reg  [31:0]             prescale;
	reg  [31:0]             presc_cnt;
	reg  [3*NUM_MATCH-1:0]  match_ctrl;
	reg  [5:0]              cap_ctrl;
	reg  [31:0]             cap0;
	reg  [31:0]             cap1;
	reg  [7:0]              ext_ctrl;
	reg  [2:0]              count_ctrl;
	reg  [NUM_PWM:1]        pwm_double;
	reg  [NUM_PWM:1]        pwm_oe;
	reg  [NUM_MATCH-1:0]    latch_en;
	reg  [1:0]              dma_en;

	// Internal state
	reg  [1:0]              cap_prev;
	reg  [NUM_PWM:1]        pwm_state;
	reg  [NUM_PWM:1]        next_pwm;
	reg  [3:0]              next_ext;
	reg  [8:0]              events;
	integer                 k;
	integer                 j;

	// Per-match buses gathered from the match units
	wire [32*NUM_MATCH-1:0] shadow_flat;
	wire [32*NUM_MATCH-1:0] active_flat;
	wire [NUM_MATCH-1:0]    hit;
	wire [NUM_MATCH-1:0]    mr_reset;
	wire [NUM_MATCH-1:0]    mr_stop;
	wire [NUM_MATCH-1:0]    mr_int;

	// Mode and run state; the counter reset bit freezes counting
	wire pwm_mode = ctrl[`CTRL_PWM_MODE];
	wire running  = ctrl[`CTRL_ENABLE] && !ctrl[`CTRL_RESET];

	// Edge detect on capture inputs; inputs are already synchronous
	wire [1:0] cap_rise = cap_in & ~cap_prev;
	wire [1:0] cap_fall = ~cap_in & cap_prev;
	wire [1:0] cap_evt  = (cap_rise & {cap_ctrl[3+`CC_RISE], cap_ctrl[`CC_RISE]})
	                    | (cap_fall & {cap_ctrl[3+`CC_FALL], cap_ctrl[`CC_FALL]});

	// Count source: every clock in timer mode, chosen input edges otherwise
	wire       src_sel  = count_ctrl[`CNT_SEL_BIT];
	wire       src_rise = src_sel ? cap_rise[1] : cap_rise[0];
	wire       src_fall = src_sel ? cap_fall[1] : cap_fall[0];
	reg        count_en;
	always @* begin
		case (count_ctrl[1:0])
		`CNT_MODE_TIMER: count_en = 1'b1;
		`CNT_MODE_RISE:  count_en = src_rise;
		`CNT_MODE_FALL:  count_en = src_fall;
		`CNT_MODE_BOTH:  count_en = src_rise | src_fall;
		default:         count_en = 1'b0;
		endcase
	end

	// Prescaler expiry advances the count by one, or clears it when a resetting match hits
	wire tick = running && count_en && (presc_cnt == prescale);

	// Period start: match 0 in PWM mode reloads released match values
	wire period_start = pwm_mode && hit[0];

	// Match units, one per match register
	genvar g;
	generate
		for (g = 0; g < NUM_MATCH; g = g + 1) begin : g_match
			localparam integer OFS_I = `OFS_MATCH0 + 4 * g;
			localparam [7:0]   OFS   = OFS_I[7:0];
			match_unit #(
				.W        (32)
			) u_match (
				.clk      (clk),
				.rst_b    (rst_b),
				.wr_en    (wr_en && (addr == OFS)),
				.wr_data  (wr_data),
				.buffered (pwm_mode),
				.load_now (period_start && latch_en[g]),
				.count    (count),
				.tick     (tick),
				.shadow   (shadow_flat[32*g +: 32]),
				.active   (active_flat[32*g +: 32]),
				.hit      (hit[g])
			);
			assign mr_int[g]   = match_ctrl[3*g + `MC_INT];
			assign mr_stop[g]  = match_ctrl[3*g + `MC_STOP];
			// Match 0 always closes the period in PWM mode
			assign mr_reset[g] = match_ctrl[3*g + `MC_RESET] ||
			                     (g == 0 && pwm_mode);
		end
	endgenerate

	// Actions of every match that hits on this tick
	wire any_reset = |(hit & mr_reset);
	wire any_stop  = |(hit & mr_stop);

	// Interrupt sources: seven matches then two captures
	always @* begin
		events = {cap_evt & {cap_ctrl[3+`CC_INT], cap_ctrl[`CC_INT]},
		          hit & mr_int};
	end

	// Level interrupt while any unmasked flag stands
	assign irq = |(int_status & int_mask);

	// Match outputs: act on matches 0..3 by the two-bit action field
	always @* begin
		next_ext = ext_match;
		for (j = 0; j < 4; j = j + 1) begin
			if (hit[j]) begin
				case (ext_ctrl[2*j +: 2])
				`EM_LOW:    next_ext[j] = 1'b0;
				`EM_HIGH:   next_ext[j] = 1'b1;
				`EM_TOGGLE: next_ext[j] = ~ext_match[j];
				default:    next_ext[j] = ext_match[j];
				endcase
			end
		end
	end

	// PWM outputs; a clear at the same count as a set wins to avoid slivers
	always @* begin
		next_pwm = pwm_state;
		for (k = 1; k <= NUM_PWM; k = k + 1) begin
			if (!pwm_mode) begin
				next_pwm[k] = 1'b0;
			end else if (pwm_double[k] && k > 1) begin
				if (hit[k-1])
					next_pwm[k] = 1'b1;
				if (hit[k])
					next_pwm[k] = 1'b0;
			end else begin
				// Zero duty means constant low, so skip the rise
				if (hit[0] && active_flat[32*k +: 32] != 32'h0000_0000)
					next_pwm[k] = 1'b1;
				if (hit[k])
					next_pwm[k] = 1'b0;
			end
		end
	end

	// Counter, prescaler, captures and outputs
	always @(posedge clk) begin
		if (!rst_b) begin
			count     <= `RST_WORD;
			presc_cnt <= `RST_WORD;
			cap0      <= `RST_WORD;
			cap1      <= `RST_WORD;
			cap_prev  <= 2'h0;
			ext_match <= 4'h0;
			pwm_state <= {NUM_PWM{1'b0}};
			pwm_out   <= {NUM_PWM{1'b0}};
			dma_req   <= 2'h0;
		end else begin
			cap_prev <= cap_in;
			if (cap_evt[0])
				cap0 <= count;
			if (cap_evt[1])
				cap1 <= count;
			if (ctrl[`CTRL_RESET]) begin
				count     <= `RST_WORD;
				presc_cnt <= `RST_WORD;
			end else if (wr_en && addr == `OFS_COUNT) begin
				count <= wr_data;
			end else if (wr_en && addr == `OFS_PRESC_CNT) begin
				presc_cnt <= wr_data;
			end else if (running && count_en) begin
				if (tick) begin
					presc_cnt <= `RST_WORD;
					count <= any_reset ? `RST_WORD : count + 32'h0000_0001;
				end else begin
					presc_cnt <= presc_cnt + 32'h0000_0001;
				end
			end
			if (wr_en && addr == `OFS_EXT_MATCH)
				ext_match <= wr_data[3:0];
			else
				ext_match <= next_ext;
			pwm_state <= next_pwm;
			pwm_out   <= next_pwm & pwm_oe;
			dma_req   <= hit[1:0] & dma_en;
		end
	end

	// Software-written registers; hardware set wins over a same-cycle clear
	always @(posedge clk) begin
		if (!rst_b) begin
			int_status <= 9'h000;
			int_mask   <= 9'h000;
			ctrl       <= 4'h0;
			prescale   <= `RST_WORD;
			match_ctrl <= {3*NUM_MATCH{1'b0}};
			cap_ctrl   <= 6'h00;
			ext_ctrl   <= 8'h00;
			count_ctrl <= 3'h0;
			pwm_double <= {NUM_PWM{1'b0}};
			pwm_oe     <= {NUM_PWM{1'b0}};
			latch_en   <= {NUM_MATCH{1'b0}};
			dma_en     <= 2'h0;
		end else begin
			if (wr_en && addr == `OFS_INT_STATUS)
				int_status <= (int_status & ~wr_data[8:0]) | events;
			else
				int_status <= int_status | events;
			if (wr_en && addr == `OFS_CTRL)
				ctrl <= wr_data[3:0];
			else if (any_stop)
				ctrl[`CTRL_ENABLE] <= 1'b0;
			// Release bits clear once their values are in use
			if (wr_en && addr == `OFS_LATCH_EN)
				latch_en <= wr_data[NUM_MATCH-1:0];
			else if (period_start)
				latch_en <= {NUM_MATCH{1'b0}};
			if (wr_en) begin
				case (addr)
				`OFS_INT_MASK:   int_mask   <= wr_data[8:0];
				`OFS_PRESCALE:   prescale   <= wr_data;
				`OFS_MATCH_CTRL: match_ctrl <= wr_data[3*NUM_MATCH-1:0];
				`OFS_CAP_CTRL:   cap_ctrl   <= wr_data[5:0];
				`OFS_EXT_MATCH:  ext_ctrl   <= wr_data[11:4];
				`OFS_COUNT_CTRL: count_ctrl <= wr_data[2:0];
				`OFS_DMA_CTRL:   dma_en     <= wr_data[1:0];
				`OFS_PWM_CTRL: begin
					pwm_double <= wr_data[NUM_PWM:1];
					pwm_oe     <= wr_data[NUM_PWM+8:9];
				end
				default: ;
				endcase
			end
		end
	end

	// Match index of a read address; offset 0x1C maps to match 0
	wire [2:0]              rd_mi = addr[4:2] - 3'h7;

	// Read port: data stand in the cycle after the strobe, zero otherwise
	always @(posedge clk) begin
		if (!rst_b) begin
			rd_data <= `RST_WORD;
		end else if (!rd_en) begin
			rd_data <= `RST_WORD;
		end else begin
			case (addr)
			`OFS_INT_STATUS: rd_data <= {23'h00_0000, int_status};
			`OFS_INT_MASK:   rd_data <= {23'h00_0000, int_mask};
			`OFS_CTRL:       rd_data <= {28'h000_0000, ctrl};
			`OFS_COUNT:      rd_data <= count;
			`OFS_PRESCALE:   rd_data <= prescale;
			`OFS_PRESC_CNT:  rd_data <= presc_cnt;
			`OFS_MATCH_CTRL: rd_data <= {11'h000, match_ctrl};
			`OFS_CAP_CTRL:   rd_data <= {26'h000_0000, cap_ctrl};
			`OFS_CAP0:       rd_data <= cap0;
			`OFS_CAP1:       rd_data <= cap1;
			`OFS_EXT_MATCH:  rd_data <= {20'h0_0000, ext_ctrl, ext_match};
			`OFS_COUNT_CTRL: rd_data <= {29'h0000_0000, count_ctrl};
			`OFS_PWM_CTRL:   rd_data <= {17'h0_0000, pwm_oe, 2'h0, pwm_double, 1'b0};
			`OFS_LATCH_EN:   rd_data <= {25'h000_0000, latch_en};
			`OFS_DMA_CTRL:   rd_data <= {30'h0000_0000, dma_en};
			default: begin
				// Match registers read back the last written value
				if (addr >= `OFS_MATCH0 && addr <= `OFS_MATCH6 && addr[1:0] == 2'h0)
					rd_data <= shadow_flat[32*rd_mi +: 32];
				else
					rd_data <= `RST_WORD;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

// *** bench/timer_pwm_asserts.sv ***
// Purpose: Port checks of the timer/PWM block
// Assumes: Bound to timer_counter_pwm
// Notes:   Offsets are literals of the map
`timescale 1ns/100ps
`default_nettype none
module timer_pwm_asserts #(
	parameter NUM_MATCH = 7,
	parameter NUM_PWM   = 6
) (
	// Clock and reset
	input wire logic             clk,
	input wire logic             rst_b,
	// Register port
	input wire logic [7:0]       addr,
	input wire logic [31:0]      wr_data,
	input wire logic             wr_en,
	input wire logic             rd_en,
	input wire logic [31:0]      rd_data,
	// Pins
	input wire logic [1:0]       cap_in,
	input wire logic [3:0]       ext_match,
	input wire logic [NUM_PWM:1] pwm_out,
	input wire logic [1:0]       dma_req,
	input wire logic             irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Reset must clear outputs even while it is held
	a_rst_quiet: assert property (disable iff (1'b0) !rst_b |=>
		!irq && pwm_out == 0 && dma_req == 0 && ext_match == 0) else $error("outputs after reset");
	a_rd_idle: assert property (!rd_en |=> rd_data == 0)
		else $error("read data without read");
	a_rd_unmapped: assert property (rd_en && addr == 8'h60 |=> rd_data == 0)
		else $error("unmapped read not zero");
	a_irq_masked: assert property (wr_en && addr == 8'h04 && wr_data == 0 |=> !irq)
		else $error("irq with all masked");
	a_irq_has_flag: assert property (rd_en && addr == 8'h00 && irq |=> rd_data != 0)
		else $error("irq without status flag");
	a_pwm_off: assert property (wr_en && addr == 8'h4C && wr_data[14:9] == 0 |->
		##2 pwm_out == 0) else $error("pwm output while disabled");
	a_extm_write: assert property (wr_en && addr == 8'h44 |=>
		ext_match == $past(wr_data[3:0])) else $error("match pins ignore write");
	a_dma_off: assert property (wr_en && addr == 8'h54 && wr_data[1:0] == 0 |->
		##2 dma_req == 0) else $error("dma request while off");
	// Main scenarios reached
	c_irq: cover property ($rose(irq));
	c_pwm: cover property (pwm_out != 0);
	c_dma: cover property (dma_req != 0);
endmodule
bind timer_counter_pwm timer_pwm_asserts #(.NUM_MATCH(NUM_MATCH), .NUM_PWM(NUM_PWM)) u_asrt (
	.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .cap_in(cap_in), .ext_match(ext_match), .pwm_out(pwm_out),
	.dma_req(dma_req), .irq(irq));
`default_nettype wire

// *** bench/event_pins.sv ***
// Purpose: Far-side pins: event inputs and DMA request tally
// Assumes: Edges launched just after a rising clock edge
// Notes:   Inputs are always driven, so never left floating
`timescale 1ns/100ps
`default_nettype none
module event_pins (
	// Clock and tally clear
	input wire logic        clk,
	input wire logic        dma_clr,
	// Pins
	input wire logic [1:0]  dma_req,
	output var logic [1:0]  cap_in,
	// Pulse tallies
	output var logic [31:0] n_dma0,
	output var logic [31:0] n_dma1
);
	initial cap_in = 2'b00;
	// One transition, held long enough to be sampled
	task automatic flip(input int ch);
		@(posedge clk);
		cap_in[ch] <= ~cap_in[ch];
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Count request pulses; one-cycle pulses count once each
	always @(posedge clk) begin
		n_dma0 <= dma_clr ? 32'h0000_0000 : n_dma0 + dma_req[0];
		n_dma1 <= dma_clr ? 32'h0000_0000 : n_dma1 + dma_req[1];
	end
endmodule
`default_nettype wire

// *** bench/timer_counter_pwm_tb.sv ***
// Purpose: Self-checking bench of the timer/PWM block
// Assumes: Read data stands in the cycle after the read strobe
// Notes:   Duty is judged over whole periods, so pipeline offset drops out
`timescale 1ns/100ps
`default_nettype none
`include "timer_pwm_regs.vh"
module timer_counter_pwm_tb;
	logic        clk, rst_b, wr_en, rd_en, dma_clr, irq;
	logic [7:0]  addr;
	logic [31:0] wr_data, rd_data, v, n_dma0, n_dma1, h1, h3, h4;
	logic [1:0]  cap_in, dma_req;
	logic [3:0]  ext_match;
	logic [6:1]  pwm_out;
	int          miscompares, n_compared, t;
	timer_counter_pwm u_timer_counter_pwm (.clk(clk), .rst_b(rst_b), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .cap_in(cap_in),
		.ext_match(ext_match), .pwm_out(pwm_out), .dma_req(dma_req), .irq(irq));
	event_pins u_event_pins (.clk(clk), .dma_clr(dma_clr), .dma_req(dma_req),
		.cap_in(cap_in), .n_dma0(n_dma0), .n_dma1(n_dma1));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Register port cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s: expected %h, seen %h", s, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d, wrong %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// High cycles of three outputs over four 11-cycle periods
	task automatic duty;
		h1 = 0;
		h3 = 0;
		h4 = 0;
		repeat (30) @(posedge clk);
		repeat (44) begin
			@(posedge clk) #1;
			h1 += pwm_out[1];
			h3 += pwm_out[3];
			h4 += pwm_out[4];
		end
	endtask
	task automatic t_regs;
		rd(`OFS_COUNT, v);
		chk("count", 0, v);
		wr(`OFS_MATCH6, 32'hDEAD_BEEF);
		rd(`OFS_MATCH6, v);
		chk("match6", 32'hDEAD_BEEF, v);
		rd(8'h60, v);
		chk("unmapped", 0, v);
		$display("test regs done");
	endtask
	task automatic t_timer;
		wr(`OFS_PRESCALE, 32'h0000_0003);
		wr(`OFS_MATCH0 + 8'h04, 32'h0000_0005);
		wr(`OFS_MATCH_CTRL, 32'h0000_0018);
		wr(`OFS_INT_MASK, 32'h0000_0002);
		wr(`OFS_CTRL, 32'h0000_0002);
		wr(`OFS_CTRL, 32'h0000_0001);
		t = 0;
		while (irq !== 1'b1 && t < 100) begin
			@(posedge clk) #1 t++;
		end
		chk("irq delay", 1, t >= 22 && t <= 27);
		rd(`OFS_INT_STATUS, v);
		chk("status", 32'h0000_0002, v);
		wr(`OFS_CTRL, 0);
		wr(`OFS_INT_STATUS, 32'hFFFF_FFFF);
		rd(`OFS_COUNT, v);
		chk("count bound", 1, v <= 5);
		chk("irq clear", 0, irq);
		$display("test timer done");
	endtask
	task automatic t_stop;
		wr(`OFS_PRESCALE, 0);
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_MATCH0 + 8'(4 * i), 32'h0000_0002);
		end
		wr(`OFS_MATCH_CTRL, 32'h0000_0004);
		wr(`OFS_EXT_MATCH, 32'h0000_0399);
		wr(`OFS_DMA_CTRL, 32'h0000_0003);
		wr(`OFS_CTRL, 32'h0000_0002);
		wr(`OFS_CTRL, 32'h0000_0001);
		repeat (10) @(posedge clk);
		rd(`OFS_COUNT, v);
		chk("stop count", 32'h0000_0003, v);
		chk("match pins", 32'h0000_000E, ext_match);
		chk("dma0", 1, n_dma0);
		chk("dma1", 1, n_dma1);
		rd(`OFS_CTRL, v);
		chk("stop enable", 0, v);
		wr(`OFS_DMA_CTRL, 0);
		$display("test stop done");
	endtask
	task automatic t_capture;
		wr(`OFS_CAP_CTRL, 32'h0000_0015);
		wr(`OFS_INT_MASK, 32'h0000_0080);
		u_event_pins.flip(0);
		chk("cap irq", 1, irq);
		rd(`OFS_INT_STATUS, v);
		chk("cap flag", 32'h0000_0080, v);
		rd(`OFS_CAP0, v);
		chk("cap0", 32'h0000_0003, v);
		u_event_pins.flip(1);
		rd(`OFS_CAP1, v);
		chk("cap1 rise", 0, v);
		u_event_pins.flip(1);
		rd(`OFS_CAP1, v);
		chk("cap1 fall", 32'h0000_0003, v);
		wr(`OFS_INT_STATUS, 32'h0000_0180);
		wr(`OFS_INT_MASK, 0);
		$display("test capture done");
	endtask
	task automatic t_extcount;
		wr(`OFS_CAP_CTRL, 0);
		wr(`OFS_MATCH_CTRL, 0);
		wr(`OFS_COUNT_CTRL, 32'h0000_0001);
		wr(`OFS_CTRL, 32'h0000_0002);
		wr(`OFS_CTRL, 32'h0000_0001);
		repeat (10) u_event_pins.flip(0);
		rd(`OFS_COUNT, v);
		chk("edge count", 32'h0000_0005, v);
		wr(`OFS_COUNT_CTRL, 32'h0000_0007);
		wr(`OFS_CTRL, 32'h0000_0002);
		wr(`OFS_CTRL, 32'h0000_0001);
		repeat (3) u_event_pins.flip(1);
		rd(`OFS_COUNT, v);
		chk("both edges", 32'h0000_0003, v);
		wr(`OFS_CTRL, 0);
		wr(`OFS_COUNT_CTRL, 0);
		$display("test extcount done");
	endtask
	task automatic t_pwm;
		wr(`OFS_CTRL, 32'h0000_0002);
		wr(`OFS_MATCH0, 32'h0000_000A);
		wr(`OFS_MATCH0 + 8'h04, 32'h0000_0003);
		wr(`OFS_MATCH0 + 8'h08, 32'h0000_0002);
		wr(`OFS_MATCH0 + 8'h0C, 32'h0000_0007);
		wr(`OFS_MATCH0 + 8'h10, 0);
		wr(`OFS_PWM_CTRL, 32'h0000_1A08);
		wr(`OFS_CTRL, 32'h0000_0009);
		duty;
		chk("single", 16, h1);
		chk("double", 20, h3);
		chk("const low", 0, h4);
		wr(`OFS_MATCH0 + 8'h04, 32'h0000_0006);
		duty;
		chk("held", 16, h1);
		wr(`OFS_LATCH_EN, 32'h0000_0002);
		duty;
		chk("released", 28, h1);
		rd(`OFS_LATCH_EN, v);
		chk("latch clr", 0, v);
		wr(`OFS_PWM_CTRL, 0);
		wr(`OFS_CTRL, 0);
		$display("test pwm done");
	endtask
	// Reset, then the scenarios in order
	initial begin
		rst_b = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wr_data = 0;
		dma_clr = 1'b1;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		dma_clr <= 1'b0;
		t_regs;
		t_timer;
		t_stop;
		t_capture;
		t_extcount;
		t_pwm;
		report_and_stop;
	end
	// Watchdog: the scenarios need well under 1000 cycles
	initial begin
		repeat (4000) @(posedge clk);
		miscompares++;
		report_and_stop;
	end
endmodule
`default_nettype wire
